// ===== rtl/accs_ctr_if.sv
/*
  Interface carrying a countdown timer's controls between the top and the timer.
  Assumes a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface accs_ctr_if;
    logic start;
    logic stop;
    logic [31:0] load;
    logic running;
    logic expired;
    modport owner (output start, output stop, output load, input running, input expired);
    modport timer (input start, input stop, input load, output running, output expired);
endinterface : accs_ctr_if
`default_nettype wire

// ===== rtl/accs_pkg.sv
/*
  Package for the accelerator and compressor clutch signal interface logic.
  Assumes a 50 MHz system clock and ports driven by decoded network signals.
*/
package accs_pkg;
    // ============================================================
    // Clock and timing
    localparam int CLK_HZ = 50_000_000;
    localparam int SHIFT_HOLD_MS = 2500;
    localparam int IMMED_MS = 300;
    localparam int STROKE_DELAY_MS = 40;
    localparam int SHIFT_HOLD_CYC = SHIFT_HOLD_MS * (CLK_HZ / 1000);
    localparam int IMMED_CYC = IMMED_MS * (CLK_HZ / 1000);
    localparam int STROKE_DELAY_CYC = STROKE_DELAY_MS * (CLK_HZ / 1000);
    // ============================================================
    // Field widths and codes
    localparam int POS_W = 8;
    localparam logic [7:0] POS_FULL = 8'hFF;
    localparam logic VALID = 1'b0;
    localparam logic INVALID = 1'b1;
    typedef enum logic [1:0]
    {
        CLREQ_NONE = 2'h0,
        CLREQ_ENGAGE = 2'h1,
        CLREQ_DISENGAGE = 2'h2,
        CLREQ_DISENGAGE_NOW = 2'h3
    } accs_clreq_e;
    typedef enum logic [1:0]
    {
        STROKE_NONE = 2'h0,
        STROKE_ENGAGE = 2'h1,
        STROKE_MIN = 2'h2,
        STROKE_SHUTDOWN = 2'h3
    } accs_stroke_e;
endpackage : accs_pkg

// ===== rtl/accs_timer.sv
/*
  Countdown timer: start loads a count, expired pulses once when it reaches zero.
  Assumes start and stop come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module accs_timer
(
    input wire logic clk,
    input wire logic rst_n,
    accs_ctr_if.timer t
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic exp_q;
    logic exp_d;

    always_comb
    begin
        cnt_d = cnt_q;
        exp_d = 1'b0;
        if (t.stop)
        begin
            cnt_d = '0;
        end
        else if (t.start)
        begin
            cnt_d = t.load;
        end
        else if (cnt_q != '0)
        begin
            cnt_d = cnt_q - 32'h1;
            exp_d = (cnt_q == 32'h1);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign t.running = (cnt_q != '0);
    assign t.expired = exp_q;
endmodule : accs_timer
`default_nettype wire

// ===== rtl/accs_top.sv
/*
  Powertrain side of the accelerator and compressor clutch signal interface.
  Assumes network inputs arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Effective accelerator sent as 8-bit count, 0.392157 percent each.
// - Effective value is the larger of pedal and cruise request.
// - Inputs are pre-torque-intervention requests; no idle or traction terms added.
// - Clutch engaged flag equals final commanded clutch driver state.
// - Clutch request: 0 none, 1 engage, 2 disengage, 3 disengage now.
// - Disengage may be delayed during a shift, at most 2.5 s.
// - Disengage-immediately releases the clutch within 300 ms.
// - Request taken as disengage at power-up and on communication failure.
// - Request merges with own clutch logic; drives fan request without sensor.
// - Request trusted only while climate availability reads available.
// - Clutch may engage in crank, disengages on protection faults.
// - Normalized load decoded as 8-bit count of 0.1 l/min.
// - Compressor torque equals load times high pressure over engine speed.
// - Invalid load forces torque gradient limitation request until valid.
// - Stroke request two bits, held zero without clutchless compressor, 40 ms delay.
module accs_top #(
    parameter int SHIFT_HOLD_CYC = accs_pkg::SHIFT_HOLD_CYC,
    parameter int IMMED_CYC = accs_pkg::IMMED_CYC,
    parameter int STROKE_DELAY_CYC = accs_pkg::STROKE_DELAY_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [8:0] pedal_req,
    input wire logic [8:0] cruise_req,
    input wire logic pedal_fault,
    input wire logic [1:0] clutch_req_in,
    input wire logic clutch_req_fresh,
    input wire logic climate_available,
    input wire logic comm_fail,
    input wire logic shift_active,
    input wire logic crank_active,
    input wire logic protect_fault,
    input wire logic pressure_sensor_fitted,
    input wire logic [7:0] compressor_load_received,
    input wire logic load_validity,
    input wire logic [7:0] compressor_high_pressure,
    input wire logic [15:0] engine_speed,
    input wire logic ac_fitted,
    input wire logic clutchless,
    input wire logic [1:0] stroke_cmd,
    output logic [7:0] accel_eff_pos,
    output logic accel_eff_valid,
    output logic clutch_engaged,
    output logic fan_ac_request,
    output logic [15:0] compressor_torque_now,
    output logic torque_gradient_limit,
    output logic [1:0] stroke_req
);
    // ============================================================
    // Input synchronisers
    // Multi-word values are assumed held for several cycles by the sender, so a word
    // caught mid-change settles on the next cycle.
    logic [64:0] s1_q;
    logic [64:0] s2_q;
    logic [64:0] s_in;
    assign s_in = {pedal_req, cruise_req, pedal_fault, clutch_req_in, clutch_req_fresh,
                   climate_available, comm_fail, shift_active, crank_active, protect_fault,
                   load_validity, ac_fitted, clutchless, stroke_cmd, pressure_sensor_fitted,
                   compressor_load_received, compressor_high_pressure, engine_speed};
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else
        begin
            s1_q <= s_in;
            s2_q <= s1_q;
        end
    end
    logic [8:0] ped_s;
    logic [8:0] cru_s;
    logic pfault_s;
    logic [1:0] req_s;
    logic fresh_s;
    logic avail_s;
    logic cfail_s;
    logic shift_s;
    logic crank_s;
    logic prot_s;
    logic lval_s;
    logic acfit_s;
    logic cless_s;
    logic [1:0] stroke_s;
    logic psens_s;
    logic [7:0] load_s;
    logic [7:0] hp_s;
    logic [15:0] spd_s;
    assign {ped_s, cru_s, pfault_s, req_s, fresh_s, avail_s, cfail_s, shift_s, crank_s,
            prot_s, lval_s, acfit_s, cless_s, stroke_s, psens_s, load_s, hp_s, spd_s} = s2_q;

    // ============================================================
    // Accelerator effective position
    logic [7:0] pos_q;
    logic [7:0] pos_d;
    logic pval_q;
    logic pval_d;
    logic [8:0] hi;
    always_comb
    begin
        hi = (ped_s > cru_s) ? ped_s : cru_s;
        pos_d = (hi > 9'(accs_pkg::POS_FULL)) ? accs_pkg::POS_FULL : hi[7:0];
        pval_d = pfault_s ? accs_pkg::INVALID : accs_pkg::VALID;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pos_q <= '0;
            pval_q <= accs_pkg::INVALID;
        end
        else
        begin
            pos_q <= pos_d;
            pval_q <= pval_d;
        end
    end
    assign accel_eff_pos = pos_q;
    assign accel_eff_valid = pval_q;

    // ============================================================
    // Clutch request decode and clutch driver
    typedef enum logic [1:0] {CL_OFF, CL_ON, CL_HOLD} accs_cl_e;
    accs_cl_e cl_q;
    accs_cl_e cl_d;
    logic [1:0] req_q;
    logic [1:0] req_d;
    logic stale_q;
    logic stale_d;
    logic drv_q;
    logic drv_d;
    logic fan_q;
    logic fan_d;
    logic [1:0] eff_req;
    accs_ctr_if hold_t ();
    accs_timer u_hold (.clk(clk), .rst_n(rst_n), .t(hold_t));
    always_comb
    begin
        req_d = req_q;
        stale_d = stale_q;
        if (cfail_s || !avail_s)
        begin
            stale_d = 1'b1;
        end
        else if (fresh_s)
        begin
            stale_d = 1'b0;
            req_d = req_s;
        end
        eff_req = stale_q ? 2'(accs_pkg::CLREQ_DISENGAGE) : req_q;
    end
    always_comb
    begin
        cl_d = cl_q;
        hold_t.start = 1'b0;
        hold_t.stop = 1'b0;
        hold_t.load = 32'(SHIFT_HOLD_CYC);
        unique case (cl_q)
            CL_OFF:
            begin
                if (eff_req == 2'(accs_pkg::CLREQ_ENGAGE) && !prot_s)
                begin
                    cl_d = CL_ON;
                end
            end
            CL_ON:
            begin
                if (prot_s || eff_req == 2'(accs_pkg::CLREQ_DISENGAGE_NOW))
                begin
                    cl_d = CL_OFF;
                end
                else if (eff_req == 2'(accs_pkg::CLREQ_DISENGAGE))
                begin
                    if (shift_s)
                    begin
                        cl_d = CL_HOLD;
                        hold_t.start = 1'b1;
                    end
                    else
                    begin
                        cl_d = CL_OFF;
                    end
                end
            end
            CL_HOLD:
            begin
                if (prot_s || eff_req == 2'(accs_pkg::CLREQ_DISENGAGE_NOW) || !shift_s
                    || hold_t.expired || !hold_t.running)
                begin
                    cl_d = CL_OFF;
                    hold_t.stop = 1'b1;
                end
                else if (eff_req == 2'(accs_pkg::CLREQ_ENGAGE))
                begin
                    cl_d = CL_ON;
                    hold_t.stop = 1'b1;
                end
            end
            default:
            begin
                cl_d = CL_OFF;
            end
        endcase
        drv_d = ((cl_d != CL_OFF) || (crank_s && acfit_s)) && !prot_s && !cless_s;
        fan_d = !psens_s && (eff_req == 2'(accs_pkg::CLREQ_ENGAGE) || cl_d != CL_OFF);
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cl_q <= CL_OFF;
            req_q <= 2'(accs_pkg::CLREQ_DISENGAGE);
            stale_q <= 1'b1;
            drv_q <= 1'b0;
            fan_q <= 1'b0;
        end
        else
        begin
            cl_q <= cl_d;
            req_q <= req_d;
            stale_q <= stale_d;
            drv_q <= drv_d;
            fan_q <= fan_d;
        end
    end
    assign clutch_engaged = drv_q;
    assign fan_ac_request = fan_q;

    // ============================================================
    // Compressor torque; the divide is costly but runs one result per cycle.
    logic [15:0] tq_q;
    logic [15:0] tq_d;
    logic tgl_q;
    logic tgl_d;
    logic [15:0] prod;
    logic [15:0] quo;
    always_comb
    begin
        prod = 16'(load_s) * 16'(hp_s);
        quo = (spd_s == 16'h0000) ? 16'h0000 : prod / spd_s;
        tq_d = quo;
        tgl_d = (lval_s == accs_pkg::INVALID);
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tq_q <= '0;
            tgl_q <= 1'b1;
        end
        else
        begin
            tq_q <= tq_d;
            tgl_q <= tgl_d;
        end
    end
    assign compressor_torque_now = tq_q;
    assign torque_gradient_limit = tgl_q;

    // ============================================================
    // Stroke request with input delay
    logic [1:0] str_q;
    logic [1:0] str_d;
    logic [1:0] pend_q;
    logic [1:0] pend_d;
    logic [1:0] want;
    accs_ctr_if str_t ();
    accs_timer u_str (.clk(clk), .rst_n(rst_n), .t(str_t));
    always_comb
    begin
        want = (acfit_s && cless_s) ? stroke_s : 2'(accs_pkg::STROKE_NONE);
        pend_d = pend_q;
        str_d = str_q;
        str_t.start = 1'b0;
        str_t.stop = 1'b0;
        str_t.load = 32'(STROKE_DELAY_CYC);
        if (want != pend_q)
        begin
            pend_d = want;
            str_t.start = 1'b1;
        end
        else if (str_t.expired)
        begin
            str_d = pend_q;
        end
        if (!(acfit_s && cless_s))
        begin
            str_d = 2'(accs_pkg::STROKE_NONE);
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            str_q <= '0;
            pend_q <= '0;
        end
        else
        begin
            str_q <= str_d;
            pend_q <= pend_d;
        end
    end
    assign stroke_req = str_q;
endmodule : accs_top
`default_nettype wire

// ===== testbench/accs_plat_model.sv
/*
  Model of the climate controller that requests the compressor clutch.
  Assumes the bench steers its request, link and sensor state.
*/
`timescale 1ns/1ps
`default_nettype none
module accs_plat_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ac_on,
    input wire logic [1:0] want,
    input wire logic link_ok,
    input wire logic sig_missing,
    input wire logic [1:0] stroke_req,
    output logic [1:0] clutch_req_in,
    output logic clutch_req_fresh,
    output logic climate_available,
    output logic load_validity,
    output logic ac_running
);
    // ============================================================
    // Request generation
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clutch_req_in <= accs_pkg::CLREQ_DISENGAGE;
            clutch_req_fresh <= 1'b0;
            climate_available <= 1'b0;
            load_validity <= 1'b1;
            ac_running <= 1'b0;
        end
        else
        begin
            clutch_req_in <= ac_on ? want : accs_pkg::CLREQ_DISENGAGE;
            clutch_req_fresh <= link_ok;
            climate_available <= link_ok;
            load_validity <= sig_missing;
            ac_running <= stroke_req == accs_pkg::STROKE_ENGAGE;
        end
    end
endmodule : accs_plat_model
`default_nettype wire

// ===== testbench/accs_top_asserts.sv
/*
  Port checker for the accelerator and compressor clutch logic.
  Assumes one clock domain and the shortened timing parameters of the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module accs_top_asserts #(
    parameter int SHIFT_HOLD_CYC = 40,
    parameter int IMMED_CYC = 20,
    parameter int STROKE_DELAY_CYC = 20
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [8:0] pedal_req,
    input wire logic [8:0] cruise_req,
    input wire logic pedal_fault,
    input wire logic [1:0] clutch_req_in,
    input wire logic clutch_req_fresh,
    input wire logic climate_available,
    input wire logic comm_fail,
    input wire logic shift_active,
    input wire logic crank_active,
    input wire logic clutchless,
    input wire logic [7:0] compressor_load_received,
    input wire logic load_validity,
    input wire logic [7:0] compressor_high_pressure,
    input wire logic [15:0] engine_speed,
    input wire logic [7:0] accel_eff_pos,
    input wire logic accel_eff_valid,
    input wire logic clutch_engaged,
    input wire logic [15:0] compressor_torque_now,
    input wire logic torque_gradient_limit,
    input wire logic [1:0] stroke_req
);
    // ============================================================
    // Helper logic
    localparam int IMMED_LIM = IMMED_CYC + 8;
    localparam int STROKE_LIM = STROKE_DELAY_CYC + 8;
    logic [8:0] big;
    logic [15:0] torque_x;
    logic [31:0] hold_q;
    logic [31:0] hold_d;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_comb
    begin
        big = (pedal_req > cruise_req) ? pedal_req : cruise_req;
        torque_x = (engine_speed == 16'h0000) ? 16'h0000 :
            (16'(compressor_load_received) * 16'(compressor_high_pressure)) / engine_speed;
        hold_d = (clutch_engaged && clutch_req_in[1] && clutch_req_fresh && !crank_active) ?
            hold_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hold_q <= 32'h0;
        else
            hold_q <= hold_d;
    end
    // ============================================================
    // Assertions
    a_pos_max_sat: assert property (
        ($stable(pedal_req) && $stable(cruise_req) && !pedal_fault) [*5] |->
        accel_eff_pos == ((big > 9'h0FF) ? 8'hFF : big[7:0])) else $error("position wrong");
    a_valid_follows: assert property (
        $stable(pedal_fault) [*5] |-> accel_eff_valid == pedal_fault) else $error("validity wrong");
    a_shift_bound: assert property (
        hold_q <= SHIFT_HOLD_CYC + 8) else $error("disengage held too long");
    a_immed_release: assert property (
        (clutch_req_in == 2'h3 && clutch_req_fresh && climate_available && !comm_fail
        && !crank_active) [*3] |-> ##[0:IMMED_LIM] !clutch_engaged) else $error("slow release");
    a_comm_off: assert property (
        (comm_fail && !crank_active && !shift_active) [*6] |-> !clutch_engaged)
        else $error("engaged in comm failure");
    a_unavail_off: assert property (
        (!climate_available && !crank_active && !shift_active) [*6] |-> !clutch_engaged)
        else $error("engaged while unavailable");
    a_torque_calc: assert property (
        ($stable(compressor_load_received) && $stable(compressor_high_pressure)
        && $stable(engine_speed)) [*3] |-> compressor_torque_now == torque_x)
        else $error("torque wrong");
    a_grad_on: assert property (
        load_validity [*4] |-> torque_gradient_limit) else $error("no gradient limit");
    a_grad_off: assert property (
        !load_validity [*4] |-> !torque_gradient_limit) else $error("gradient limit stuck");
    a_stroke_idle: assert property (
        $fell(clutchless) |-> ##[0:STROKE_LIM] stroke_req == 2'h0) else $error("stroke not idle");
endmodule : accs_top_asserts
bind accs_top accs_top_asserts #(.SHIFT_HOLD_CYC(SHIFT_HOLD_CYC), .IMMED_CYC(IMMED_CYC),
    .STROKE_DELAY_CYC(STROKE_DELAY_CYC)) i_accs_top_asserts (.*);
`default_nettype wire

// ===== testbench/accs_top_bench.sv
/*
  Self-checking bench for the accelerator and compressor clutch logic.
  Assumes short timing parameters so waits stay within a few hundred cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
    begin \
        n_checks++; \
        if ((g) !== (e)) \
        begin \
            num_errors++; \
            $display("[FAIL] %s exp %0h got %0h", n, e, g); \
        end \
    end
module accs_top_bench;
    // ============================================================
    // Signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [8:0] pedal_req = 9'h000, cruise_req = 9'h000;
    logic pedal_fault = 1'b0, comm_fail = 1'b0, shift_active = 1'b0, crank_active = 1'b0;
    logic protect_fault = 1'b0, pressure_sensor_fitted = 1'b0, ac_fitted = 1'b1;
    logic clutchless = 1'b0, ac_on = 1'b1, link_ok = 1'b1, sig_missing = 1'b0;
    logic [1:0] want = 2'h0, stroke_cmd = 2'h0;
    logic [7:0] compressor_load_received = 8'h00, compressor_high_pressure = 8'h00;
    logic [15:0] engine_speed = 16'h0001;
    logic [1:0] clutch_req_in, stroke_req;
    logic clutch_req_fresh, climate_available, load_validity, ac_running;
    logic accel_eff_valid, clutch_engaged, fan_ac_request, torque_gradient_limit;
    logic [7:0] accel_eff_pos;
    logic [15:0] compressor_torque_now;
    int num_errors = 0;
    int n_checks = 0;
    always #10 clk = ~clk;
    accs_top #(.SHIFT_HOLD_CYC(40), .IMMED_CYC(20), .STROKE_DELAY_CYC(20)) i_accs_top (.clk,
        .rst_n, .pedal_req, .cruise_req, .pedal_fault, .clutch_req_in, .clutch_req_fresh,
        .climate_available, .comm_fail, .shift_active, .crank_active, .protect_fault,
        .pressure_sensor_fitted, .compressor_load_received, .load_validity,
        .compressor_high_pressure, .engine_speed, .ac_fitted, .clutchless, .stroke_cmd,
        .accel_eff_pos, .accel_eff_valid, .clutch_engaged, .fan_ac_request,
        .compressor_torque_now, .torque_gradient_limit, .stroke_req);
    accs_plat_model i_accs_plat_model (.clk, .rst_n, .ac_on, .want, .link_ok, .sig_missing,
        .stroke_req, .clutch_req_in, .clutch_req_fresh, .climate_available, .load_validity,
        .ac_running);
    // ============================================================
    // Tasks
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic wait_cl(input logic v, input int lim, input string n);
        int i;
        for (i = 0; i < lim && clutch_engaged !== v; i++)
            step(1);
        `CHK(n, v, clutch_engaged)
    endtask : wait_cl
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic t_accel;
        pedal_req = 9'h064;
        cruise_req = 9'h032;
        step(6);
        `CHK("pos", 8'h64, accel_eff_pos)
        cruise_req = 9'h0C8;
        step(6);
        `CHK("pos", 8'hC8, accel_eff_pos)
        pedal_req = 9'h12C;
        step(6);
        `CHK("pos", 8'hFF, accel_eff_pos)
        `CHK("valid", 1'b0, accel_eff_valid)
        pedal_fault = 1'b1;
        step(6);
        `CHK("valid", 1'b1, accel_eff_valid)
        pedal_fault = 1'b0;
    endtask : t_accel
    task automatic t_clutch;
        want = accs_pkg::CLREQ_ENGAGE;
        wait_cl(1'b1, 10, "engage");
        `CHK("fan", 1'b1, fan_ac_request)
        want = accs_pkg::CLREQ_NONE;
        step(6);
        `CHK("none", 1'b1, clutch_engaged)
        shift_active = 1'b1;
        want = accs_pkg::CLREQ_DISENGAGE;
        wait_cl(1'b0, 50, "shift");
        shift_active = 1'b0;
        want = accs_pkg::CLREQ_ENGAGE;
        wait_cl(1'b1, 10, "engage");
        shift_active = 1'b1;
        want = accs_pkg::CLREQ_DISENGAGE_NOW;
        wait_cl(1'b0, 28, "now");
        shift_active = 1'b0;
        want = accs_pkg::CLREQ_ENGAGE;
        wait_cl(1'b1, 10, "engage");
        ac_on = 1'b0;
        wait_cl(1'b0, 10, "no ac");
        ac_on = 1'b1;
        wait_cl(1'b1, 10, "engage");
        comm_fail = 1'b1;
        wait_cl(1'b0, 10, "comm");
        comm_fail = 1'b0;
        wait_cl(1'b1, 10, "engage");
        link_ok = 1'b0;
        wait_cl(1'b0, 10, "unavail");
        link_ok = 1'b1;
        want = accs_pkg::CLREQ_DISENGAGE;
        crank_active = 1'b1;
        wait_cl(1'b1, 10, "crank");
        crank_active = 1'b0;
        protect_fault = 1'b1;
        want = accs_pkg::CLREQ_ENGAGE;
        step(8);
        `CHK("protect", 1'b0, clutch_engaged)
        protect_fault = 1'b0;
        wait_cl(1'b1, 10, "engage");
        pressure_sensor_fitted = 1'b1;
        step(6);
        `CHK("fan sensor", 1'b0, fan_ac_request)
        pressure_sensor_fitted = 1'b0;
    endtask : t_clutch
    task automatic t_load;
        compressor_load_received = 8'h64;
        compressor_high_pressure = 8'h32;
        engine_speed = 16'h00FA;
        step(6);
        `CHK("torque", 16'h0014, compressor_torque_now)
        `CHK("grad", 1'b0, torque_gradient_limit)
        engine_speed = 16'h0000;
        step(6);
        `CHK("torque", 16'h0000, compressor_torque_now)
        sig_missing = 1'b1;
        step(6);
        `CHK("grad", 1'b1, torque_gradient_limit)
        sig_missing = 1'b0;
        step(6);
        `CHK("grad", 1'b0, torque_gradient_limit)
    endtask : t_load
    task automatic t_stroke;
        int c;
        clutchless = 1'b1;
        for (c = 1; c < 5; c++)
        begin
            stroke_cmd = c[1:0];
            step(28);
            `CHK("stroke", c[1:0], stroke_req)
            if (c == 1)
                `CHK("ac on", 1'b1, ac_running)
        end
        stroke_cmd = accs_pkg::STROKE_ENGAGE;
        ac_fitted = 1'b0;
        step(28);
        `CHK("stroke", 2'h0, stroke_req)
        ac_fitted = 1'b1;
        clutchless = 1'b0;
        step(28);
        `CHK("stroke", 2'h0, stroke_req)
    endtask : t_stroke
    // ============================================================
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        #2;
        `CHK("rst clutch", 1'b0, clutch_engaged)
        `CHK("rst valid", 1'b1, accel_eff_valid)
        `CHK("rst stroke", 2'h0, stroke_req)
        rst_n = 1'b1;
        t_accel();
        t_clutch();
        t_load();
        t_stroke();
        end_sim();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        end_sim();
    end
endmodule : accs_top_bench
`default_nettype wire
